// ---- core/crossbar_defines.vh ----
`ifndef CROSSBAR_DEFINES_VH
`define CROSSBAR_DEFINES_VH
// Crossbar geometry
`define XB_NUM_PINS      24
`define XB_PIN_IDX_W     5
`define XB_NUM_SLOTS     14
`define XB_SLOT_W        4
// Routed function slots in priority order
`define XB_SLOT_SMB_SDA  4'h0
`define XB_SLOT_SMB_SCL  4'h1
`define XB_SLOT_UART_TX  4'h2
`define XB_SLOT_UART_RX  4'h3
`define XB_SLOT_SPI_SCK  4'h4
`define XB_SLOT_SPI_MISO 4'h5
`define XB_SLOT_SPI_MOSI 4'h6
`define XB_SLOT_SPI_NSS  4'h7
`define XB_SLOT_SYSTEM_CLOCK_OUTPUT   4'h8
`define XB_SLOT_CEX0     4'h9
`define XB_SLOT_CEX1     4'hA
`define XB_SLOT_CEX2     4'hB
`define XB_SLOT_ECI      4'hC
`define XB_SLOT_T0       4'hD
`define XB_SLOT_T1       4'hE
`define XB_SLOT_NONE     4'hF
// Slave-select mode field values
`define XB_NSS_3WIRE     2'h0
// Reset values
`define XB_MDIN_RESET    1'b1
`define XB_SKIP_RESET    1'b0
`endif

// ---- core/pin_sync.v ----
`timescale 1ns/1ns
`default_nettype none
// Two-flop synchroniser per pad input
module pin_sync
#(
  parameter WIDTH = 24
)
(
  input  wire             clock_in,
  input  wire             rst_in,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      meta_q <= {WIDTH{1'b1}};
      sync_q <= {WIDTH{1'b1}};
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule // pin_sync
`default_nettype wire

// ---- core/priority_decoder.v ----
`include "crossbar_defines.vh"
`timescale 1ns/1ns
`default_nettype none
// Walks the pins from lowest upward, handing each free pin the next
// requested function in priority order.
module priority_decoder
#(
  parameter NUM_PINS  = 24,
  parameter NUM_SLOTS = 15
)
(
  input  wire [NUM_SLOTS-1:0]  request_in,
  input  wire [NUM_PINS-1:0]   skip_in,
  output reg  [NUM_PINS*4-1:0] pin_slot_out,
  output reg  [NUM_PINS-1:0]   pin_routed_out
);
  integer p;
  integer s;
  reg [NUM_SLOTS-1:0] left;
  reg                 found;

  always @*
  begin
    left = request_in;
    pin_slot_out = {NUM_PINS{`XB_SLOT_NONE}};
    pin_routed_out = {NUM_PINS{1'b0}};
    for (p = 0; p < NUM_PINS; p = p + 1)
    begin
      found = 1'b0;
      if (!skip_in[p])
      begin
        for (s = 0; s < NUM_SLOTS; s = s + 1)
        begin
          if (left[s] && !found)
          begin
            found = 1'b1;
            left[s] = 1'b0;
            pin_slot_out[p*4 +: 4] = s[3:0];
            pin_routed_out[p] = 1'b1;
          end
        end
      end
    end
  end
endmodule // priority_decoder
`default_nettype wire

// ---- core/priority_crossbar_pin_assign.v ----
`include "crossbar_defines.vh"
`timescale 1ns/1ns
`default_nettype none
module priority_crossbar_pin_assign
#(
  parameter NUM_PINS = `XB_NUM_PINS
)
(
  input  wire                clock_in,
  input  wire                rst_in,
  // Configuration
  input  wire                crossbar_route_enable_in,
  input  wire [NUM_PINS-1:0] port_skip_mask_in,
  input  wire [NUM_PINS-1:0] port_input_mode_in,
  input  wire                smbus_unit_enable_in,
  input  wire                uart_unit_enable_in,
  input  wire                spi_unit_enable_in,
  input  wire [1:0]          slave_select_mode_field_in,
  input  wire                system_clock_output_enable_in,
  input  wire [2:0]          pca_channel_count_in,
  input  wire                pca_external_count_input_enable_in,
  input  wire                timer_zero_input_enable_in,
  input  wire                timer_one_input_enable_in,
  // Port latch and push-pull select
  input  wire [NUM_PINS-1:0] port_latch_in,
  input  wire [NUM_PINS-1:0] port_push_pull_in,
  // Peripheral outputs
  input  wire                smbus_sda_out_in,
  input  wire                smbus_scl_out_in,
  input  wire                uart_tx_in,
  input  wire                spi_sck_out_in,
  input  wire                spi_miso_out_in,
  input  wire                spi_mosi_out_in,
  input  wire                spi_nss_out_in,
  input  wire                system_clock_output_in,
  input  wire [2:0]          pca_channel_outputs_in,
  // Pads
  input  wire [NUM_PINS-1:0] pad_in,
  output reg  [NUM_PINS-1:0] pad_out,
  output reg  [NUM_PINS-1:0] pad_oe_out,
  output reg  [NUM_PINS-1:0] pad_pullup_out,
  // Peripheral inputs from routed pins
  output reg                 smbus_sda_in_out,
  output reg                 smbus_scl_in_out,
  output reg                 uart_rx_out,
  output reg                 spi_sck_in_out,
  output reg                 spi_mosi_in_out,
  output reg                 spi_miso_in_out,
  output reg                 spi_nss_in_out,
  output reg                 pca_external_count_input_out,
  output reg                 timer_zero_input_out,
  output reg                 timer_one_input_out,
  // Fixed digital functions and routed-pin map
  output reg  [NUM_PINS-1:0] fixed_pin_level_out,
  output reg  [NUM_PINS-1:0] fixed_pin_edge_out,
  output reg  [NUM_PINS-1:0] pin_routed_out
);
  localparam NSLOT = `XB_NUM_SLOTS + 1;

  wire [NUM_PINS-1:0]   pad_sync;
  wire [NUM_PINS*4-1:0] pin_slot;
  wire [NUM_PINS-1:0]   pin_routed;
  wire [NUM_PINS-1:0]   pad_out_d;
  wire [NUM_PINS-1:0]   pad_oe_d;
  wire [NUM_PINS-1:0]   pad_pullup_d;
  wire [NUM_PINS-1:0]   digital_level;
  wire [2:0]            pca_request;
  wire                  nss_request;
  reg  [NSLOT-1:0]      request;
  reg  [NSLOT-1:0]      slot_drive;
  reg  [NSLOT-1:0]      slot_in_d;
  reg  [NUM_PINS-1:0]   prev_level_q;
  reg  [3:0]            sl;
  integer               i;
  genvar                g;
  genvar                c;

  pin_sync #(
    .WIDTH (NUM_PINS)
  ) u_sync (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .async_in (pad_in),
    .sync_out (pad_sync)
  );

  // Slave select needs a pin only in four-wire mode
  assign nss_request = spi_unit_enable_in &&
    (slave_select_mode_field_in != `XB_NSS_3WIRE);

  // PCA channel n routes while the channel count exceeds n and is at most 3
  generate
    for (c = 0; c < 3; c = c + 1)
    begin : pca_req
      localparam [2:0] CHANNEL = c;
      assign pca_request[c] = (pca_channel_count_in > CHANNEL) &&
        (pca_channel_count_in <= 3'h3);
    end
  endgenerate

  // Requested functions in priority order
  always @*
  begin
    request = {NSLOT{1'b0}};
    if (crossbar_route_enable_in)
    begin
      request[`XB_SLOT_SMB_SDA]  = smbus_unit_enable_in;
      request[`XB_SLOT_SMB_SCL]  = smbus_unit_enable_in;
      request[`XB_SLOT_UART_TX]  = uart_unit_enable_in;
      request[`XB_SLOT_UART_RX]  = uart_unit_enable_in;
      request[`XB_SLOT_SPI_SCK]  = spi_unit_enable_in;
      request[`XB_SLOT_SPI_MISO] = spi_unit_enable_in;
      request[`XB_SLOT_SPI_MOSI] = spi_unit_enable_in;
      request[`XB_SLOT_SPI_NSS]  = nss_request;
      request[`XB_SLOT_SYSTEM_CLOCK_OUTPUT]   = system_clock_output_enable_in;
      request[`XB_SLOT_CEX0] = pca_request[0];
      request[`XB_SLOT_CEX1] = pca_request[1];
      request[`XB_SLOT_CEX2] = pca_request[2];
      request[`XB_SLOT_ECI] = pca_external_count_input_enable_in;
      request[`XB_SLOT_T0]  = timer_zero_input_enable_in;
      request[`XB_SLOT_T1]  = timer_one_input_enable_in;
    end
  end

  // Combinational priority walk
  priority_decoder #(
    .NUM_PINS  (NUM_PINS),
    .NUM_SLOTS (NSLOT)
  ) u_decode (
    .request_in     (request),
    .skip_in        (port_skip_mask_in),
    .pin_slot_out   (pin_slot),
    .pin_routed_out (pin_routed)
  );

  // Peripheral output value per slot; input-only slots drive high
  always @*
  begin
    slot_drive = {NSLOT{1'b1}};
    slot_drive[`XB_SLOT_SMB_SDA]  = smbus_sda_out_in;
    slot_drive[`XB_SLOT_SMB_SCL]  = smbus_scl_out_in;
    slot_drive[`XB_SLOT_UART_TX]  = uart_tx_in;
    slot_drive[`XB_SLOT_SPI_SCK]  = spi_sck_out_in;
    slot_drive[`XB_SLOT_SPI_MISO] = spi_miso_out_in;
    slot_drive[`XB_SLOT_SPI_MOSI] = spi_mosi_out_in;
    slot_drive[`XB_SLOT_SPI_NSS]  = spi_nss_out_in;
    slot_drive[`XB_SLOT_SYSTEM_CLOCK_OUTPUT]   = system_clock_output_in;
    slot_drive[`XB_SLOT_CEX0]     = pca_channel_outputs_in[0];
    slot_drive[`XB_SLOT_CEX1]     = pca_channel_outputs_in[1];
    slot_drive[`XB_SLOT_CEX2]     = pca_channel_outputs_in[2];
  end

  // Per-pin drive value, driver enables and digital receiver
  generate
    for (g = 0; g < NUM_PINS; g = g + 1)
    begin : pad_cell
      wire [3:0] cell_slot;
      wire       cell_digital;
      wire       cell_value;
      wire       cell_oe;
      assign cell_slot = pin_slot[g*4 +: 4];
      assign cell_digital = port_input_mode_in[g];
      // Unrouted pins act as port I/O
      assign cell_value = pin_routed[g] ? slot_drive[cell_slot] :
        port_latch_in[g];
      // Drivers stay off while the crossbar is disabled
      assign cell_oe = crossbar_route_enable_in && cell_digital &&
        (port_push_pull_in[g] || !cell_value);
      // Pull-up off on analog pins and on pins driving low
      assign pad_pullup_d[g] = cell_digital && !(cell_oe && !cell_value);
      assign pad_out_d[g] = cell_value;
      assign pad_oe_d[g] = cell_oe;
      // Analog pins show a quiet zero to fixed functions
      assign digital_level[g] = cell_digital & pad_sync[g];
    end
  endgenerate

  // Routed pad levels back to peripheral inputs
  always @*
  begin
    slot_in_d = {NSLOT{1'b1}};
    sl = `XB_SLOT_NONE;
    for (i = 0; i < NUM_PINS; i = i + 1)
    begin
      sl = pin_slot[i*4 +: 4];
      if (pin_routed[i])
      begin
        slot_in_d[sl] = digital_level[i];
      end
    end
  end

  // Pad drive registers
  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pad_out <= {NUM_PINS{1'b1}};
      pad_oe_out <= {NUM_PINS{1'b0}};
      pad_pullup_out <= {NUM_PINS{1'b1}};
    end
    else
    begin
      pad_out <= pad_out_d;
      pad_oe_out <= pad_oe_d;
      pad_pullup_out <= pad_pullup_d;
    end
  end

  // Peripheral input registers, idle high
  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      smbus_sda_in_out <= 1'b1;
      smbus_scl_in_out <= 1'b1;
      uart_rx_out <= 1'b1;
      spi_sck_in_out <= 1'b1;
      spi_mosi_in_out <= 1'b1;
      spi_miso_in_out <= 1'b1;
      spi_nss_in_out <= 1'b1;
      pca_external_count_input_out <= 1'b1;
      timer_zero_input_out <= 1'b1;
      timer_one_input_out <= 1'b1;
    end
    else
    begin
      smbus_sda_in_out <= slot_in_d[`XB_SLOT_SMB_SDA];
      smbus_scl_in_out <= slot_in_d[`XB_SLOT_SMB_SCL];
      uart_rx_out <= slot_in_d[`XB_SLOT_UART_RX];
      spi_sck_in_out <= slot_in_d[`XB_SLOT_SPI_SCK];
      spi_mosi_in_out <= slot_in_d[`XB_SLOT_SPI_MOSI];
      spi_miso_in_out <= slot_in_d[`XB_SLOT_SPI_MISO];
      spi_nss_in_out <= slot_in_d[`XB_SLOT_SPI_NSS];
      pca_external_count_input_out <= slot_in_d[`XB_SLOT_ECI];
      timer_zero_input_out <= slot_in_d[`XB_SLOT_T0];
      timer_one_input_out <= slot_in_d[`XB_SLOT_T1];
    end
  end

  // Fixed function level and edge; reset high like a pulled-up pad
  // so that release of reset shows no false edge except on analog pins
  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      fixed_pin_level_out <= {NUM_PINS{1'b1}};
      fixed_pin_edge_out <= {NUM_PINS{1'b0}};
      prev_level_q <= {NUM_PINS{1'b1}};
    end
    else
    begin
      fixed_pin_level_out <= digital_level;
      prev_level_q <= digital_level;
      fixed_pin_edge_out <= digital_level ^ prev_level_q;
    end
  end

  // Ownership map of routed pins
  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pin_routed_out <= {NUM_PINS{1'b0}};
    end
    else
    begin
      pin_routed_out <= pin_routed;
    end
  end
endmodule // priority_crossbar_pin_assign
`default_nettype wire

// ---- verif/pad_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module pad_model
(
  input  wire logic        clock_in,
  input  wire logic [23:0] drv_in,
  input  wire logic [23:0] oe_in,
  input  wire logic [23:0] pull_in,
  input  wire logic [23:0] ext_oe_in,
  input  wire logic [23:0] ext_in,
  output var  logic [23:0] level_out
);
  logic [23:0] float_q = 24'h000000;
  // Floating pads wander
  always @(posedge clock_in)
    float_q <= ~float_q;
  always_comb
    for (int i = 0; i < 24; i++)
      level_out[i] = oe_in[i] ? drv_in[i] : ext_oe_in[i] ? ext_in[i] :
                     pull_in[i] ? 1'h1 : float_q[i];
endmodule // pad_model
`default_nettype wire

// ---- verif/priority_crossbar_pin_assign_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
module crossbar_sva
#(
  parameter NUM_PINS = 24
)
(
  input wire logic                clock_in,
  input wire logic                rst_in,
  input wire logic                crossbar_route_enable_in,
  input wire logic [NUM_PINS-1:0] port_skip_mask_in,
  input wire logic [NUM_PINS-1:0] port_input_mode_in,
  input wire logic                smbus_unit_enable_in,
  input wire logic                uart_unit_enable_in,
  input wire logic                spi_unit_enable_in,
  input wire logic [1:0]          slave_select_mode_field_in,
  input wire logic [NUM_PINS-1:0] pad_oe_out,
  input wire logic [NUM_PINS-1:0] pad_pullup_out,
  input wire logic [NUM_PINS-1:0] fixed_pin_level_out,
  input wire logic [NUM_PINS-1:0] fixed_pin_edge_out,
  input wire logic [NUM_PINS-1:0] pin_routed_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  logic [NUM_PINS-1:0] lvl_q;
  wire                 en = crossbar_route_enable_in;
  always @(posedge clock_in or posedge rst_in)
    if (rst_in)
      lvl_q <= '1;
    else
      lvl_q <= fixed_pin_level_out;
  reset_pads_a: assert property (disable iff (1'h0)
    rst_in |=> pad_oe_out == '0 && &pad_pullup_out && pin_routed_out == '0)
    else $error("pads not idle in reset");
  xbar_off_a: assert property (!en |=>
    pad_oe_out == '0 && pin_routed_out == '0) else $error("drive while off");
  skip_free_a: assert property (1'h1 |=>
    (pin_routed_out & $past(port_skip_mask_in)) == '0)
    else $error("skipped pin routed");
  analog_quiet_a: assert property (1'h1 |=>
    (~$past(port_input_mode_in) & (pad_oe_out | pad_pullup_out)) == '0)
    else $error("analog pin active");
  smbus_pair_a: assert property (en && smbus_unit_enable_in &&
    port_skip_mask_in[1:0] == 2'h0 |=> pin_routed_out[1:0] == 2'h3)
    else $error("bus pair not on lowest pins");
  routed_contig_a: assert property (en && port_skip_mask_in == '0 |=>
    ((pin_routed_out + 1'h1) & pin_routed_out) == '0)
    else $error("routed pins not contiguous");
  spi_four_a: assert property (en && spi_unit_enable_in &&
    !smbus_unit_enable_in && !uart_unit_enable_in &&
    slave_select_mode_field_in != 2'h0 && port_skip_mask_in[3:0] == 4'h0
    |=> pin_routed_out[3:0] == 4'hF) else $error("four wire pins missing");
  edge_level_a: assert property (1'h1 |=>
    fixed_pin_edge_out == (fixed_pin_level_out ^ lvl_q))
    else $error("edge not matching level change");
  cover property (en ##1 pin_routed_out[7]);
  cover property (|fixed_pin_edge_out);
  cover property (!en ##1 en);
endmodule // crossbar_sva
bind priority_crossbar_pin_assign crossbar_sva #(.NUM_PINS(NUM_PINS)) chk (.*);
`default_nettype wire

// ---- verif/test_priority_crossbar_pin_assign.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected %0t %h %h", $time, g, e); end end
module test_priority_crossbar_pin_assign;
  logic        clock_in = 1'h0, rst_in = 1'h1, en = 1'h0, smb = 1'h0;
  logic        urt = 1'h0, spi = 1'h0, clko = 1'h0, cnt = 1'h0;
  logic        tmr0 = 1'h0, tmr1 = 1'h0;
  logic [1:0]  ssm = 2'h0;
  logic [2:0]  pca = 3'h0;
  logic [10:0] pv = 11'h7FF;
  logic [23:0] skip = 24'h0, mode = 24'hFFFFFF, latch = 24'hFFFFFF;
  logic [23:0] pp = 24'h0, drv = 24'h0, extv = 24'h0, pad;
  wire  [23:0] po, oe, pu, lvl, edg, rtd;
  wire         tz, to;
  int          err_count = 0, checked = 0;
  logic [6:0]  tf [10] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h00, 7'h00,
                           7'h04, 7'h02, 7'h01, 7'h7F};
  logic [2:0]  tp [10] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h3, 3'h5, 3'h0,
                           3'h0, 3'h0, 3'h3};
  logic [23:0] tr [10] = '{24'h3, 24'h3, 24'hF, 24'h1, 24'h7, 24'h0,
                           24'h1, 24'h1, 24'h1, 24'h7FFF};
  priority_crossbar_pin_assign uut (.clock_in(clock_in), .rst_in(rst_in),
    .crossbar_route_enable_in(en), .port_skip_mask_in(skip),
    .port_input_mode_in(mode), .smbus_unit_enable_in(smb),
    .uart_unit_enable_in(urt), .spi_unit_enable_in(spi),
    .slave_select_mode_field_in(ssm), .system_clock_output_enable_in(clko),
    .pca_channel_count_in(pca), .pca_external_count_input_enable_in(cnt),
    .timer_zero_input_enable_in(tmr0), .timer_one_input_enable_in(tmr1),
    .port_latch_in(latch), .port_push_pull_in(pp),
    .smbus_sda_out_in(pv[0]), .smbus_scl_out_in(pv[1]), .uart_tx_in(pv[2]),
    .spi_sck_out_in(pv[4]), .spi_miso_out_in(pv[5]),
    .spi_mosi_out_in(pv[6]), .spi_nss_out_in(pv[3]),
    .system_clock_output_in(pv[7]), .pca_channel_outputs_in(pv[10:8]),
    .pad_in(pad), .pad_out(po), .pad_oe_out(oe), .pad_pullup_out(pu),
    .smbus_sda_in_out(), .smbus_scl_in_out(), .uart_rx_out(),
    .spi_sck_in_out(), .spi_mosi_in_out(), .spi_miso_in_out(),
    .spi_nss_in_out(), .pca_external_count_input_out(),
    .timer_zero_input_out(tz), .timer_one_input_out(to),
    .fixed_pin_level_out(lvl), .fixed_pin_edge_out(edg),
    .pin_routed_out(rtd));
  pad_model far (.clock_in(clock_in), .drv_in(po), .oe_in(oe), .pull_in(pu),
    .ext_oe_in(drv), .ext_in(extv), .level_out(pad));
  initial
    forever #2 clock_in = ~clock_in;
  task automatic final_report;
    if (err_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic run(input int n);
    repeat (n) @(posedge clock_in);
    @(negedge clock_in);
  endtask
  task automatic set(input logic e, input logic [23:0] sk,
                     input logic [6:0] f, input logic [1:0] m,
                     input logic [2:0] pc);
    @(posedge clock_in);
    en <= e;
    skip <= sk;
    {smb, urt, spi, clko, cnt, tmr0, tmr1} <= f;
    ssm <= m;
    pca <= pc;
    run(2);
  endtask
  initial
  begin
    run(4);
    `CHK(oe, 24'h000000)
    `CHK(pu, 24'hFFFFFF)
    repeat (5) @(posedge clock_in);
    rst_in <= 1'h0;
    latch <= 24'h000000;
    set(1'h0, 24'h0, 7'h7F, 2'h1, 3'h3);
    `CHK(oe, 24'h000000)
    `CHK(rtd, 24'h000000)
    set(1'h1, 24'h0, 7'h00, 2'h1, 3'h0);
    `CHK(oe, 24'hFFFFFF)
    @(posedge clock_in);
    latch <= 24'hFFFFFF;
    pv <= 11'h7EF;
    set(1'h1, 24'h000318, 7'h50, 2'h1, 3'h2);
    `CHK(rtd, 24'h000CE7)
    `CHK(po, 24'hFFFFFB)
    set(1'h1, 24'h000318, 7'h50, 2'h0, 3'h2);
    `CHK(rtd, 24'h0004E7)
    for (int i = 0; i < 10; i++)
    begin
      set(1'h1, 24'h0, tf[i], 2'h1, tp[i]);
      `CHK(rtd, tr[i])
    end
    @(posedge clock_in);
    pv <= 11'h77F;
    set(1'h1, 24'h000002, 7'h28, 2'h0, 3'h0);
    `CHK(rtd, 24'h00000D)
    `CHK(po, 24'hFFFFF7)
    @(posedge clock_in);
    drv <= 24'h000046;
    extv <= 24'h000044;
    mode <= 24'hFFFFBF;
    set(1'h1, 24'h000041, 7'h03, 2'h0, 3'h0);
    run(4);
    `CHK(tz, 1'h0)
    `CHK(to, 1'h1)
    `CHK(lvl[2:1], 2'h2)
    `CHK({lvl[6], pu[6], oe[6]}, 3'h0)
    @(posedge clock_in);
    extv <= 24'h000046;
    run(3);
    `CHK(lvl[1], 1'h1)
    `CHK(edg[1], 1'h1)
    run(0);
    `CHK(edg[1], 1'h0)
    final_report;
  end
  initial
  begin
    repeat (1000) @(posedge clock_in);
    err_count++;
    final_report;
  end
endmodule // test_priority_crossbar_pin_assign
`default_nettype wire
